/* sfqcd_buf.sv */
// small valid/ready buffer for decoded command headers
`timescale 1ns/1ps
`default_nettype none
`include "sfqcd_defs.svh"

module sfqcd_buf #(
  parameter int unsigned DEPTH = `SFQCD_BUF_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire sfqcd_pkg::sfqcd_cmd_t in_data,
  output logic out_valid,
  input wire logic out_ready,
  output var sfqcd_pkg::sfqcd_cmd_t out_data
);
  import sfqcd_pkg::*;

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [PW:0] FULL = (PW + 1)'(DEPTH);

  sfqcd_cmd_t mem_q [DEPTH];
  logic [PW-1:0] wp_q, rp_q;
  logic [PW:0] cnt_q;
  logic do_wr, do_rd;

  // handshakes are honest full and empty
  assign in_ready = (cnt_q != FULL);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rp_q];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  // storage writes
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem_q[wp_q] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_wr) begin
        wp_q <= (wp_q == LAST) ? '0 : wp_q + 1'b1;
      end
      if (do_rd) begin
        rp_q <= (rp_q == LAST) ? '0 : rp_q + 1'b1;
      end
      if (do_wr && !do_rd) begin
        cnt_q <= cnt_q + {{PW{1'b0}}, 1'b1};
      end else if (do_rd && !do_wr) begin
        cnt_q <= cnt_q - {{PW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // sfqcd_buf

`default_nettype wire

/* sfqcd_decode.sv */
// serial flash opcode decoder with single-line and four-line command modes
`timescale 1ns/1ps
`default_nettype none
`include "sfqcd_defs.svh"

module sfqcd_decode (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  input wire logic dummy_count_bit_low,
  input wire logic dummy_count_bit_high,
  input wire logic [7:0] out_byte,
  output logic out_byte_take,
  output var sfqcd_pkg::sfqcd_cmd_t cmd_rec,
  output logic cmd_valid,
  input wire logic cmd_ready,
  output logic four_line_command_mode,
  output logic reset_mem_pulse
);
  import sfqcd_pkg::*;

  logic sclk_m, sclk_s, sclk_p, cs_m, cs_s, cs_p;
  logic [3:0] io_m, io_s;
  logic sclk_rise, sclk_fall, cs_rise, cs_fall;
  sfqcd_state_t st_q;
  logic [7:0] opc_q, opc_nx, osr_q, osrc;
  logic [2:0] bit_q, bit_nx, lines_q, dline_q, aline_nx, dline_nx, abyte_q, ob_q;
  logic [31:0] addr_q, addr_nx;
  logic [3:0] dcnt_q, dum_q, dum_nx, io_out_q, io_oe_q;
  logic [1:0] dc_sel;
  sfqcd_info_t info_q, info_nx;
  logic byte_done, quad_q, armed_q, reset_q, take_q;
  logic exec_ok, enter_ev, exit_ev, push_valid, push_ready;
  sfqcd_cmd_t push_rec;

  // opcode table: legality per mode, address bytes, default dummies, direction
  function automatic sfqcd_info_t op_info(input logic [7:0] op, input logic qm);
    sfqcd_info_t i;
    logic s;
    logic q;
    i = '0;
    s = 1'h0;
    q = 1'h0;
    case (op)
      8'h03, 8'h5A: begin s = 1'h1; i.rd = 1'h1; i.abytes = `SFQCD_ADDR_3; end
      8'h0B, 8'h3B, 8'h6B: begin
        s = 1'h1; i.rd = 1'h1; i.abytes = `SFQCD_ADDR_3;
        i.dummy = `SFQCD_DUMMY_FAST; i.dcsel = 1'h1;
      end
      `SFQCD_OP_DUAL_RD: begin
        s = 1'h1; i.rd = 1'h1; i.abytes = `SFQCD_ADDR_3;
        i.dummy = `SFQCD_DUMMY_DUAL; i.dcsel = 1'h1;
      end
      `SFQCD_OP_QUAD_RD: begin
        s = 1'h1; q = 1'h1; i.rd = 1'h1; i.abytes = `SFQCD_ADDR_3;
        i.dummy = `SFQCD_DUMMY_QUAD; i.dcsel = 1'h1;
      end
      8'h02, 8'h20, 8'h52, 8'hD8: begin
        s = 1'h1; q = 1'h1; i.bnd = 1'h1; i.abytes = `SFQCD_ADDR_3;
      end
      `SFQCD_OP_QUAD_PP: begin s = 1'h1; i.bnd = 1'h1; i.abytes = `SFQCD_ADDR_3; end
      8'h60, 8'hC7, 8'h06, 8'h04, 8'h68, 8'h75, 8'hB0, 8'h7A, 8'h30, 8'hB9, 8'h00,
      8'h66, 8'h99, 8'h7E, 8'h98, 8'h41, 8'h01, 8'h2F, 8'hC0, 8'hB1, 8'hC1: begin
        s = 1'h1; q = 1'h1; i.bnd = 1'h1;
      end
      `SFQCD_OP_ENTER_QUAD, 8'h2C, 8'hE4: begin s = 1'h1; i.bnd = 1'h1; end
      `SFQCD_OP_EXIT_QUAD: begin q = 1'h1; i.bnd = 1'h1; end
      8'h9F, 8'h90, 8'h2D: begin s = 1'h1; i.rd = 1'h1; end
      8'hAF: begin q = 1'h1; i.rd = 1'h1; end
      8'hAB, 8'h05, 8'h15, 8'h2B: begin s = 1'h1; q = 1'h1; i.rd = 1'h1; end
      8'hE3, 8'hE1: begin s = 1'h1; i.bnd = 1'h1; i.abytes = `SFQCD_ADDR_4; end
      8'hE2, 8'hE0: begin s = 1'h1; i.rd = 1'h1; i.abytes = `SFQCD_ADDR_4; end
      default: i = '0;
    endcase
    i.ok = qm ? q : s;
    return i;
  endfunction

  // shift one clock's worth of input lines into a word, msb first
  function automatic logic [31:0] shift_in(input logic [31:0] v, input logic [2:0] n,
                                           input logic [3:0] d);
    logic [31:0] r;
    r = {v[30:0], d[0]};
    if (n == `SFQCD_LINES_2) begin
      r = {v[29:0], d[1:0]};
    end
    if (n == `SFQCD_LINES_4) begin
      r = {v[27:0], d};
    end
    return r;
  endfunction

  // two-stage synchronisers for all pin inputs
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclk_m <= 1'h0;
      sclk_s <= 1'h0;
      sclk_p <= 1'h0;
      cs_m <= 1'h1;
      cs_s <= 1'h1;
      cs_p <= 1'h1;
      io_m <= 4'h0;
      io_s <= 4'h0;
    end else begin
      sclk_m <= sclk;
      sclk_s <= sclk_m;
      sclk_p <= sclk_s;
      cs_m <= cs_n;
      cs_s <= cs_m;
      cs_p <= cs_s;
      io_m <= io_in;
      io_s <= io_m;
    end
  end

  // edges of the synchronised link clock and select
  assign sclk_rise = sclk_s && !sclk_p;
  assign sclk_fall = !sclk_s && sclk_p;
  assign cs_rise = cs_s && !cs_p;
  assign cs_fall = !cs_s && cs_p;

  // next values of the input shifters and the opcode lookup
  assign opc_nx = 8'(shift_in({24'h000000, opc_q}, lines_q, io_s));
  assign addr_nx = shift_in(addr_q, lines_q, io_s);
  assign bit_nx = bit_q + lines_q;
  assign byte_done = (bit_nx == 3'h0);
  assign info_nx = op_info(opc_nx, quad_q);
  assign dc_sel = {dummy_count_bit_high, dummy_count_bit_low};

  // dummy count and line widths of the phases after the opcode
  always_comb begin
    dum_nx = info_nx.dummy;
    if (info_nx.dcsel) begin
      case (dc_sel)
        2'h1: dum_nx = `SFQCD_DUMMY_DC1;
        2'h2: dum_nx = `SFQCD_DUMMY_DC2;
        2'h3: dum_nx = `SFQCD_DUMMY_DC3;
        default: dum_nx = info_nx.dummy;
      endcase
    end
    aline_nx = `SFQCD_LINES_1;
    dline_nx = `SFQCD_LINES_1;
    if (quad_q) begin
      aline_nx = `SFQCD_LINES_4;
      dline_nx = `SFQCD_LINES_4;
    end else if (opc_nx == `SFQCD_OP_DUAL_RD) begin
      aline_nx = `SFQCD_LINES_2;
      dline_nx = `SFQCD_LINES_2;
    end else if (opc_nx == `SFQCD_OP_QUAD_RD) begin
      aline_nx = `SFQCD_LINES_4;
      dline_nx = `SFQCD_LINES_4;
    end else if (opc_nx == `SFQCD_OP_DUAL_OUT) begin
      dline_nx = `SFQCD_LINES_2;
    end else if (opc_nx == `SFQCD_OP_QUAD_OUT || opc_nx == `SFQCD_OP_QUAD_PP) begin
      dline_nx = `SFQCD_LINES_4;
    end
  end

  // frame sequencer: opcode, address, dummy, header push, data
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_IDLE;
      opc_q <= 8'h00;
      bit_q <= 3'h0;
      lines_q <= `SFQCD_LINES_1;
      dline_q <= `SFQCD_LINES_1;
      abyte_q <= 3'h0;
      addr_q <= 32'h00000000;
      dcnt_q <= 4'h0;
      dum_q <= 4'h0;
      info_q <= '0;
    end else if (cs_fall) begin
      st_q <= ST_CMD;
      opc_q <= 8'h00;
      bit_q <= 3'h0;
      addr_q <= 32'h00000000;
      lines_q <= quad_q ? `SFQCD_LINES_4 : `SFQCD_LINES_1;
    end else if (cs_s) begin
      // a header still waiting for buffer space outlives the select rise
      if (st_q == ST_PUSH) begin
        if (push_ready) begin
          st_q <= ST_IDLE;
        end
      end else if (st_q != ST_STBY) begin
        st_q <= ST_IDLE;
      end
    end else if (st_q == ST_PUSH) begin
      if (push_ready) begin
        st_q <= ST_DATA;
        lines_q <= dline_q;
        bit_q <= 3'h0;
      end
    end else if (sclk_rise) begin
      if (st_q == ST_CMD || st_q == ST_ADDR || st_q == ST_DATA) begin
        bit_q <= bit_nx;
      end
      case (st_q)
        ST_CMD: begin
          opc_q <= opc_nx;
          if (byte_done) begin
            info_q <= info_nx;
            dum_q <= dum_nx;
            dcnt_q <= dum_nx;
            abyte_q <= info_nx.abytes;
            lines_q <= aline_nx;
            dline_q <= dline_nx;
            if (!info_nx.ok) begin
              st_q <= ST_STBY;
            end else if (info_nx.abytes != 3'h0) begin
              st_q <= ST_ADDR;
            end else if (dum_nx != 4'h0) begin
              st_q <= ST_DUMMY;
            end else begin
              st_q <= ST_PUSH;
            end
          end
        end
        ST_ADDR: begin
          addr_q <= addr_nx;
          if (byte_done) begin
            abyte_q <= abyte_q - 3'h1;
            if (abyte_q == 3'h1) begin
              st_q <= (dum_q != 4'h0) ? ST_DUMMY : ST_PUSH;
            end
          end
        end
        ST_DUMMY: begin
          dcnt_q <= dcnt_q - 4'h1;
          if (dcnt_q == 4'h1) begin
            st_q <= ST_PUSH;
          end
        end
        default: st_q <= st_q;
      endcase
    end
  end

  // header record into the two-entry buffer; a new frame while still stalled drops it
  assign push_valid = (st_q == ST_PUSH);
  assign push_rec = '{opcode: opc_q, addr: addr_q, dummy: dum_q, quad: quad_q};

  sfqcd_buf u_buf (
    .clk(ref_clk),
    .rst(rst),
    .in_valid(push_valid),
    .in_ready(push_ready),
    .in_data(push_rec),
    .out_valid(cmd_valid),
    .out_ready(cmd_ready),
    .out_data(cmd_rec)
  );

  // output shifter: loads a byte and shifts on each link clock fall
  assign osrc = (ob_q == 3'h0) ? out_byte : osr_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      osr_q <= 8'h00;
      ob_q <= 3'h0;
      io_out_q <= 4'h0;
      io_oe_q <= 4'h0;
      take_q <= 1'h0;
    end else begin
      take_q <= 1'h0;
      if (cs_s || st_q != ST_DATA || !info_q.rd) begin
        ob_q <= 3'h0;
        io_oe_q <= 4'h0;
      end else if (sclk_fall) begin
        take_q <= (ob_q == 3'h0);
        ob_q <= ob_q + lines_q;
        osr_q <= osrc << lines_q;
        case (lines_q)
          `SFQCD_LINES_4: begin
            io_out_q <= osrc[7:4];
            io_oe_q <= 4'hF;
          end
          `SFQCD_LINES_2: begin
            io_out_q <= {2'h0, osrc[7:6]};
            io_oe_q <= 4'h3;
          end
          default: begin
            io_out_q <= {2'h0, osrc[7], 1'h0};
            io_oe_q <= 4'h2;
          end
        endcase
      end
    end
  end

  // commands that act when select rises on a byte boundary
  assign exec_ok = cs_rise && (st_q == ST_DATA || st_q == ST_PUSH) && info_q.bnd
                   && (bit_q == 3'h0);
  assign enter_ev = exec_ok && !quad_q && (opc_q == `SFQCD_OP_ENTER_QUAD);
  assign exit_ev = exec_ok && quad_q && (opc_q == `SFQCD_OP_EXIT_QUAD);

  // command-line mode; configuration bits are never written here
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      quad_q <= 1'h0;
    end else if (enter_ev) begin
      quad_q <= 1'h1;
    end else if (exit_ev) begin
      quad_q <= 1'h0;
    end
  end

  // reset-enable arming and reset-memory pulse
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      armed_q <= 1'h0;
      reset_q <= 1'h0;
    end else begin
      reset_q <= exec_ok && armed_q && (opc_q == `SFQCD_OP_RESET_MEM);
      if (cs_rise && st_q != ST_IDLE) begin
        armed_q <= exec_ok && (opc_q == `SFQCD_OP_RESET_EN);
      end
    end
  end

  assign io_out = io_out_q;
  assign io_oe = io_oe_q;
  assign out_byte_take = take_q;
  assign four_line_command_mode = quad_q;
  assign reset_mem_pulse = reset_q;

  chk_quad_entry: assert property (@(posedge ref_clk) disable iff (rst)
    enter_ev |=> four_line_command_mode) else $error("quad entry missed");
  chk_quad_exit_cause: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(quad_q) |-> $past(exit_ev)) else $error("quad left without exit");
  chk_frame_lines: assert property (@(posedge ref_clk) disable iff (rst)
    cs_fall |=> lines_q == (quad_q ? 3'h4 : 3'h1)) else $error("opcode width");
  chk_quad_out_lines: assert property (@(posedge ref_clk) disable iff (rst)
    (io_oe != 4'h0 && quad_q) |-> io_oe == 4'hF) else $error("quad out width");
  chk_standby_hiz: assert property (@(posedge ref_clk) disable iff (rst)
    st_q == ST_STBY |-> io_oe == 4'h0 ##1 ($past(cs_fall) || st_q == ST_STBY))
    else $error("standby left early");
  chk_partial_byte: assert property (@(posedge ref_clk) disable iff (rst)
    (cs_rise && st_q == ST_DATA && bit_q != 3'h0) |=> $stable(quad_q) && !reset_mem_pulse)
    else $error("partial byte acted");
  chk_reset_pair: assert property (@(posedge ref_clk) disable iff (rst)
    reset_mem_pulse |-> $past(armed_q)) else $error("reset without enable");
  chk_dual_read: assert property (@(posedge ref_clk) disable iff (rst)
    (push_valid && opc_q == 8'hBB && dc_sel == 2'h0) |-> dum_q == 4'h4 && !quad_q)
    else $error("dual read header");
  chk_dummy_select: assert property (@(posedge ref_clk) disable iff (rst)
    (push_valid && info_q.dcsel && dc_sel == 2'h3) |-> dum_q == 4'hA)
    else $error("dummy select");
  chk_rise_sample: assert property (@(posedge ref_clk) disable iff (rst)
    !$stable(opc_q) |-> $past(sclk_rise) || $past(cs_fall)) else $error("sample edge");
  chk_fall_shift: assert property (@(posedge ref_clk) disable iff (rst)
    !$stable(io_out) |-> $past(sclk_fall)) else $error("shift edge");
  chk_bad_opcode: assert property (@(posedge ref_clk) disable iff (rst)
    (st_q == ST_CMD && !cs_s && !cs_fall && sclk_rise && byte_done && !info_nx.ok)
    |=> st_q == ST_STBY) else $error("unknown opcode not refused");
endmodule // sfqcd_decode

`default_nettype wire

/* sfqcd_defs.svh */
// constants for the serial flash command front end
`ifndef SFQCD_DEFS_SVH
`define SFQCD_DEFS_SVH
`define SFQCD_OP_ENTER_QUAD 8'h35
`define SFQCD_OP_EXIT_QUAD 8'hF5
`define SFQCD_OP_RESET_EN 8'h66
`define SFQCD_OP_RESET_MEM 8'h99
`define SFQCD_OP_DUAL_RD 8'hBB
`define SFQCD_OP_QUAD_RD 8'hEB
`define SFQCD_OP_DUAL_OUT 8'h3B
`define SFQCD_OP_QUAD_OUT 8'h6B
`define SFQCD_OP_QUAD_PP 8'h38
`define SFQCD_DUMMY_FAST 4'h8
`define SFQCD_DUMMY_DUAL 4'h4
`define SFQCD_DUMMY_QUAD 4'h6
`define SFQCD_DUMMY_DC1 4'h6
`define SFQCD_DUMMY_DC2 4'h8
`define SFQCD_DUMMY_DC3 4'hA
`define SFQCD_ADDR_3 3'h3
`define SFQCD_ADDR_4 3'h4
`define SFQCD_LINES_1 3'h1
`define SFQCD_LINES_2 3'h2
`define SFQCD_LINES_4 3'h4
`define SFQCD_BUF_DEPTH 2
`endif

/* sfqcd_host.sv */
// host serial flash controller model driving clock, select and data lines
`timescale 1ns/1ps
`default_nettype none

module sfqcd_host #(
  parameter int DESEL = 8 // deselect_min_time in ref_clk cycles, plain default
) (
  input wire logic ref_clk,
  output logic sclk,
  output logic cs_n,
  output logic [3:0] io_in,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe
);
  localparam int HALF = 4; // ref_clk cycles per sclk phase, 160 ns period

  // clock stands low and select high between frames
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    io_in = 4'h0;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // one clock: data set while low, outputs sampled just before the rise
  task automatic tick(input logic [3:0] d, output logic [3:0] q, output logic [3:0] oe);
    io_in = d;
    wait_cyc(HALF);
    q = io_out ^ ~io_oe; // an undriven line reads as the inverse of its last value
    oe = io_oe;
    sclk = 1'b1;
    wait_cyc(HALF);
    sclk = 1'b0;
  endtask

  // one byte msb first on 1, 2 or 4 lines; unused lines toggle
  task automatic send(input logic [7:0] b, input int lines);
    logic [3:0] q;
    logic [3:0] oe;
    logic [7:0] s;
    s = b;
    for (int i = 0; i < 8 / lines; i++) begin
      case (lines)
        1: tick({~io_in[3:1], s[7]}, q, oe);
        2: tick({~io_in[3:2], s[7:6]}, q, oe);
        default: tick(s[7:4], q, oe);
      endcase
      s = s << lines;
    end
  endtask

  // clocks with all lines toggling, used for dummy cycles
  task automatic idle(input int n);
    logic [3:0] q;
    logic [3:0] oe;
    for (int i = 0; i < n; i++) tick(~io_in, q, oe);
  endtask

  // collect one byte msb first; oe is what the last clock saw
  task automatic recv(input int lines, output logic [7:0] b, output logic [3:0] oe);
    logic [3:0] q;
    b = 8'h00;
    for (int i = 0; i < 8 / lines; i++) begin
      tick(~io_in, q, oe);
      case (lines)
        1: b = {b[6:0], q[1]};
        2: b = {b[5:0], q[1:0]};
        default: b = {b[3:0], q};
      endcase
    end
  endtask

  task automatic start();
    cs_n = 1'b0;
    wait_cyc(HALF);
  endtask

  // select rises wherever the caller stopped clocking, then stays high
  task automatic stop();
    wait_cyc(HALF);
    cs_n = 1'b1;
    io_in = ~io_in;
    wait_cyc(DESEL);
  endtask
endmodule // sfqcd_host
`default_nettype wire

/* sfqcd_pkg.sv */
// types shared by the serial flash command front end
package sfqcd_pkg;
  // decoder states, gray coded along idle-cmd-addr-dummy-data-push
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_CMD = 3'h1,
    ST_ADDR = 3'h3,
    ST_DUMMY = 3'h2,
    ST_DATA = 3'h6,
    ST_PUSH = 3'h7,
    ST_STBY = 3'h5
  } sfqcd_state_t;

  // per-opcode lookup result
  typedef struct packed {
    logic ok;
    logic [2:0] abytes;
    logic [3:0] dummy;
    logic rd;
    logic bnd;
    logic dcsel;
  } sfqcd_info_t;

  // decoded command header handed to the back end
  typedef struct packed {
    logic [7:0] opcode;
    logic [31:0] addr;
    logic [3:0] dummy;
    logic quad;
  } sfqcd_cmd_t;
endpackage

/* tb.sv */
// self-checking bench for the serial flash command front end
`timescale 1ns/1ps
`default_nettype none

module tb;
  import sfqcd_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic dummy_count_bit_low = 1'b0;
  logic dummy_count_bit_high = 1'b0;
  logic [7:0] out_byte = 8'hA5;
  logic cmd_ready = 1'b1;
  wire logic sclk;
  wire logic cs_n;
  wire logic [3:0] io_in;
  wire logic [3:0] io_out;
  wire logic [3:0] io_oe;
  wire logic out_byte_take;
  wire logic cmd_valid;
  wire logic four_line_command_mode;
  wire logic reset_mem_pulse;
  sfqcd_cmd_t cmd_rec;
  sfqcd_cmd_t recs[$];
  int num_errors = 0;
  int checks_done = 0;
  int pulses = 0;

  always #10 ref_clk = ~ref_clk;

  sfqcd_decode uut (.ref_clk(ref_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe), .dummy_count_bit_low(dummy_count_bit_low),
    .dummy_count_bit_high(dummy_count_bit_high), .out_byte(out_byte),
    .out_byte_take(out_byte_take), .cmd_rec(cmd_rec), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .four_line_command_mode(four_line_command_mode),
    .reset_mem_pulse(reset_mem_pulse));

  sfqcd_host host (.ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe));

  // log accepted headers and reset pulses
  always @(posedge ref_clk) begin
    if (cmd_valid === 1'b1 && cmd_ready === 1'b1) recs.push_back(cmd_rec);
    if (reset_mem_pulse === 1'b1) pulses++;
  end

  // next output byte once the current one was taken
  always @(negedge ref_clk) if (out_byte_take === 1'b1) out_byte <= out_byte + 8'h01;

  task automatic conclude();
    $display("Checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic expect_eq(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // whole frame of one opcode byte
  task automatic op1(input logic [7:0] op, input int lines);
    host.start();
    host.send(op, lines);
    host.stop();
  endtask

  task automatic t_reset();
    expect_eq(io_oe, 4'h0, "oe after reset");
    expect_eq(cmd_valid, 1'b0, "valid after reset");
    expect_eq(four_line_command_mode, 1'b0, "mode after reset");
  endtask

  // single-line status read over two bytes
  task automatic t_single_read();
    logic [7:0] b;
    logic [3:0] oe;
    recs.delete();
    out_byte = 8'hA5;
    host.start();
    host.send(8'h05, 1);
    host.recv(1, b, oe);
    expect_eq(b, 8'hA5, "single byte 0");
    expect_eq(oe, 4'h2, "single oe");
    host.recv(1, b, oe);
    expect_eq(b, 8'hA6, "single byte 1");
    host.stop();
    expect_eq(io_oe, 4'h0, "oe after frame");
    expect_eq(recs.size(), 1, "single records");
    if (recs.size() > 0) expect_eq(recs[0].opcode, 8'h05, "single opcode");
  endtask

  // dual address-and-data read under every dummy-count setting
  task automatic t_dual_read();
    logic [7:0] b;
    logic [3:0] oe;
    logic [3:0] dtab [4] = '{4'h4, 4'h6, 4'h8, 4'hA};
    for (int k = 0; k < 4; k++) begin
      @(negedge ref_clk);
      dummy_count_bit_low = k[0];
      dummy_count_bit_high = k[1];
      recs.delete();
      out_byte = 8'h5A;
      host.start();
      host.send(8'hBB, 1);
      host.send(8'h12, 2);
      host.send(8'h34, 2);
      host.send(8'h56, 2);
      host.idle(int'(dtab[k]));
      host.recv(2, b, oe);
      host.stop();
      expect_eq(b, 8'h5A, "dual byte");
      expect_eq(oe, 4'h3, "dual oe");
      expect_eq(recs.size(), 1, "dual records");
      if (recs.size() > 0) expect_eq(recs[0].addr[23:0], 24'h123456, "dual addr");
      if (recs.size() > 0) expect_eq(recs[0].dummy, dtab[k], "dual dummy");
    end
    dummy_count_bit_low = 1'b0;
    dummy_count_bit_high = 1'b0;
  endtask

  // four-line address and data read issued in single-line command mode
  task automatic t_quad_io();
    logic [7:0] b;
    logic [3:0] oe;
    recs.delete();
    out_byte = 8'h96;
    host.start();
    host.send(8'hEB, 1);
    host.send(8'hAB, 4);
    host.send(8'hCD, 4);
    host.send(8'hEF, 4);
    host.idle(6);
    host.recv(4, b, oe);
    host.stop();
    expect_eq(b, 8'h96, "four-line byte");
    expect_eq(oe, 4'hF, "four-line oe");
    expect_eq(recs.size(), 1, "four-line records");
    if (recs.size() > 0) expect_eq(recs[0].addr[23:0], 24'hABCDEF, "four-line addr");
    if (recs.size() > 0) expect_eq(recs[0].dummy, 4'h6, "four-line dummy");
  endtask

  // enter, use and leave four-line mode
  task automatic t_quad();
    logic [7:0] b;
    logic [3:0] oe;
    op1(8'h35, 1);
    expect_eq(four_line_command_mode, 1'b1, "quad entered");
    recs.delete();
    host.start();
    host.send(8'hBB, 4);
    host.idle(6);
    host.recv(4, b, oe);
    host.stop();
    expect_eq(oe, 4'h0, "standby oe");
    expect_eq(recs.size(), 0, "standby records");
    out_byte = 8'h3C;
    host.start();
    host.send(8'h05, 4);
    host.recv(4, b, oe);
    host.stop();
    expect_eq(b, 8'h3C, "quad byte");
    expect_eq(oe, 4'hF, "quad oe");
    if (recs.size() > 0) expect_eq(recs[$].quad, 1'b1, "quad record");
    op1(8'h35, 4);
    expect_eq(four_line_command_mode, 1'b1, "no exit by 35h");
    host.start();
    host.send(8'hF5, 4);
    host.idle(1);
    host.stop();
    expect_eq(four_line_command_mode, 1'b1, "partial exit");
    op1(8'hF5, 4);
    expect_eq(four_line_command_mode, 1'b0, "quad left");
    out_byte = 8'hC3;
    host.start();
    host.send(8'h05, 1);
    host.recv(1, b, oe);
    host.stop();
    expect_eq(b, 8'hC3, "single after exit");
  endtask

  // reset-memory needs reset-enable right before it, on a byte boundary
  task automatic t_reset_mem();
    pulses = 0;
    op1(8'h66, 1);
    op1(8'h99, 1);
    expect_eq(pulses, 1, "reset accepted");
    op1(8'h66, 1);
    op1(8'h06, 1);
    op1(8'h99, 1);
    expect_eq(pulses, 1, "reset after other");
    op1(8'h66, 1);
    host.start();
    host.send(8'h99, 1);
    host.idle(1);
    host.stop();
    expect_eq(pulses, 1, "partial reset");
  endtask

  // consumer stalls: two headers held, third waits, none lost
  task automatic t_stall();
    int n;
    @(negedge ref_clk);
    cmd_ready = 1'b0;
    recs.delete();
    op1(8'h06, 1);
    op1(8'h04, 1);
    op1(8'h06, 1);
    expect_eq(cmd_valid, 1'b1, "stall valid");
    expect_eq(cmd_rec.opcode, 8'h06, "stall head");
    @(negedge ref_clk);
    cmd_ready = 1'b1;
    n = 0;
    while (recs.size() < 3 && n < 50) begin
      @(negedge ref_clk);
      n++;
    end
    expect_eq(recs.size(), 3, "drained count");
    if (recs.size() == 3) begin
      expect_eq(recs[1].opcode, 8'h04, "second header");
      expect_eq(recs[2].opcode, 8'h06, "third header");
    end
  endtask

  initial begin
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    t_reset();
    t_single_read();
    t_dual_read();
    t_quad_io();
    t_quad();
    t_reset_mem();
    t_stall();
    conclude();
  end

  // hang guard
  initial begin
    repeat (60000) @(posedge ref_clk);
    num_errors++;
    $display("Error at %0t: run limit reached", $time);
    conclude();
  end
endmodule // tb
`default_nettype wire
